// [hdl/bcgc_top.sv]
`timescale 1ns/1ps
`include "bcgc_defines.svh"

module bcgc_top #(
	parameter int MS_CYCLES = `BCGC_MS_NS / `BCGC_CLK_NS
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [3:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic      [31:0] rdata,
	input  wire logic        control_enable_jumper,
	input  wire logic        password_bypass_jumper,
	input  wire logic        breaker_aux_status_input,
	input  wire logic [5:0]  group_select_inputs,
	input  wire logic [7:0]  overcurrent_pickup_row,
	input  wire logic        target_reset_button,
	input  wire logic        irig_strobe,
	input  wire logic [16:0] irig_hms,
	output logic             close_out,
	output logic             trip_out,
	output logic             alarm_out,
	output logic             event_capture,
	output logic             event_summary,
	output logic             event_clear,
	output logic             copy_start,
	output logic      [2:0]  copy_src,
	output logic      [2:0]  copy_dst,
	output logic             demand_reset,
	output logic      [2:0]  active_group
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic is_delim(input logic [7:0] c);
		return c == `BCGC_CH_COLON || c == `BCGC_CH_SEMI ||
			c == `BCGC_CH_SPACE || c == `BCGC_CH_COMMA ||
			c == `BCGC_CH_SLASH;
	endfunction : is_delim

	function automatic logic pw_valid(input logic [47:0] pw);
		logic       ok;
		logic [7:0] c;
		ok = 1'b1;
		for (int i = 0; i < `BCGC_PW_CHARS; i++) begin
			c = pw[i*8 +: 8];
			if (c != `BCGC_CH_NONE && (c < `BCGC_CH_MIN ||
				c > `BCGC_CH_MAX || is_delim(c)))
				ok = 1'b0;
		end
		return ok;
	endfunction : pw_valid

	function automatic logic time_ok(input logic [16:0] t);
		return t[16:12] <= `BCGC_HOUR_LAST &&
			t[11:6] <= `BCGC_MIN_LAST && t[5:0] <= `BCGC_MIN_LAST;
	endfunction : time_ok

	function automatic logic [16:0] time_inc(input logic [16:0] t);
		logic [4:0] h;
		logic [5:0] m;
		logic [5:0] s;
		{h, m, s} = t;
		if (s != `BCGC_MIN_LAST)
			s = s + 6'h01;
		else begin
			s = 6'h00;
			if (m != `BCGC_MIN_LAST)
				m = m + 6'h01;
			else begin
				m = 6'h00;
				h = (h == `BCGC_HOUR_LAST) ? 5'h00 : h + 5'h01;
			end
		end
		return {h, m, s};
	endfunction : time_inc

	function automatic logic grp_ok(input logic [2:0] g);
		return g >= `BCGC_GRP_MIN && g <= `BCGC_GRP_MAX;
	endfunction : grp_ok

	function automatic logic [15:0] ms_count(input logic [15:0] c,
		input logic tick);
		return (tick && c != 16'hFFFF) ? c + 16'h0001 : c;
	endfunction : ms_count

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [35:0] pin_raw;
	logic [35:0] sync1_r;
	logic [35:0] sync2_r;
	logic        ctl_en_s;
	logic        pw_byp_s;
	logic        aux_s;
	logic [5:0]  gsel_s;
	logic [7:0]  pickup_s;
	logic        tgt_rst_s;
	logic        irig_stb_s;
	logic [16:0] irig_hms_s;
	logic        irig_prev_r;

	assign pin_raw = {control_enable_jumper, password_bypass_jumper,
		breaker_aux_status_input, group_select_inputs,
		overcurrent_pickup_row, target_reset_button, irig_strobe,
		irig_hms};
	assign {ctl_en_s, pw_byp_s, aux_s, gsel_s, pickup_s, tgt_rst_s,
		irig_stb_s, irig_hms_s} = sync2_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_r     <= '0;
			sync2_r     <= '0;
			irig_prev_r <= 1'b0;
		end else begin
			sync1_r     <= pin_raw;
			sync2_r     <= sync1_r;
			irig_prev_r <= irig_stb_s;
		end
	end

	// ----------------------------------------------------------------
	// registers and decode
	// ----------------------------------------------------------------
	logic                     cfg_inv_r;
	logic                     cfg_demand_reset_on_group_change_r;
	logic [5:0]               cfg_assign_r;
	logic [15:0]              cft_r;
	logic [15:0]              minimum_trip_duration_r;
	logic [47:0]              pw_stage_r;
	logic [47:0]              pw1_r;
	logic [47:0]              pw2_r;
	logic [1:0]               lvl_r;
	logic [16:0]              tim_r;
	bcgc_pkg::bcgc_state_type st_r;
	bcgc_pkg::bcgc_state_type st_nxt;
	bcgc_pkg::bcgc_op_type    pend_r;
	bcgc_pkg::bcgc_reply_type reply_r;
	bcgc_pkg::bcgc_reply_type reply_nxt;
	logic [2:0]               a_r;
	logic [2:0]               b_r;
	logic [2:0]               gvar_r;
	logic [2:0]               act_r;
	logic                     close_r;
	logic                     trip_r;

	wire        cmd     = wr_stb && addr == `BCGC_A_CMD;
	wire        time_wr = wr_stb && addr == `BCGC_A_TIME;
	wire [2:0]  arg_a   = wdata[`BCGC_F_A];
	wire [2:0]  arg_b   = wdata[`BCGC_F_B];
	wire        brk_closed = aux_s ^ cfg_inv_r;
	wire        priv    = pw_byp_s || lvl_r == `BCGC_LVL2;
	wire [47:0] pw_sel  = (arg_a == 3'(`BCGC_LVL2)) ? pw2_r : pw1_r;
	wire        lvl_arg = arg_a == 3'(`BCGC_LVL1) ||
		arg_a == 3'(`BCGC_LVL2);
	wire [20:0] hms_wr  = wdata[`BCGC_F_HMS];
	wire [16:0] hms_pk  = {hms_wr[20:16], hms_wr[13:8], hms_wr[5:0]};
	// delimiters are checked once at the write, not per character
	wire        time_set = time_wr && is_delim(wdata[`BCGC_F_SEP]) &&
		time_ok(hms_pk);
	wire        irig_load = irig_stb_s && !irig_prev_r &&
		time_ok(irig_hms_s);
	wire        granted = pw_byp_s || pw_stage_r == pw_sel;
	bcgc_pkg::bcgc_op_type op;
	assign op = bcgc_pkg::bcgc_op_type'(wdata[`BCGC_F_OP]);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_inv_r    <= 1'b0;
			cfg_demand_reset_on_group_change_r   <= 1'b0;
			cfg_assign_r <= 6'h00;
			cft_r        <= `BCGC_CFT_RST;
			minimum_trip_duration_r       <= `BCGC_MINIMUM_TRIP_DURATION_RST;
			pw_stage_r   <= 48'h0;
		end else if (wr_stb) begin
			unique case (addr)
			`BCGC_A_CFG: begin
				cfg_inv_r    <= wdata[`BCGC_F_INV];
				cfg_demand_reset_on_group_change_r   <= wdata[`BCGC_F_DEMAND_RESET_ON_GROUP_CHANGE];
				cfg_assign_r <= wdata[`BCGC_F_ASSIGN];
			end
			`BCGC_A_CFT:  cft_r  <= wdata[`BCGC_F_MS];
			`BCGC_A_MINIMUM_TRIP_DURATION: minimum_trip_duration_r <= wdata[`BCGC_F_MS];
			`BCGC_A_PWLO: pw_stage_r[31:0] <= wdata;
			`BCGC_A_PWHI: pw_stage_r[47:32] <= wdata[`BCGC_F_PWHI];
			default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// time base and time of day
	// ----------------------------------------------------------------
	logic [31:0] ms_cnt_r;
	logic [9:0]  ms_in_s_r;
	wire         ms_tick  = ms_cnt_r == 32'(MS_CYCLES - 1);
	wire         sec_tick = ms_tick && ms_in_s_r == `BCGC_MS_LAST;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ms_cnt_r  <= 32'h0;
			ms_in_s_r <= 10'h000;
			tim_r     <= 17'h0;
		end else begin
			ms_cnt_r <= ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
			if (ms_tick)
				ms_in_s_r <= sec_tick ? 10'h000 : ms_in_s_r + 10'h001;
			if (time_set)
				tim_r <= hms_pk;
			else if (irig_load)
				tim_r <= irig_hms_s;
			else if (sec_tick)
				tim_r <= time_inc(tim_r);
		end
	end

	// ----------------------------------------------------------------
	// command interpreter
	// ----------------------------------------------------------------
	logic close_go;
	logic trip_go;
	logic copy_go;
	logic gvar_go;
	logic pw_go;
	logic acc_go;
	logic trig_go;
	logic lvl2_try;
	logic close_end;
	logic cft_done;

	always_comb begin
		st_nxt    = st_r;
		reply_nxt = reply_r;
		close_go  = 1'b0;
		trip_go   = 1'b0;
		copy_go   = 1'b0;
		gvar_go   = 1'b0;
		pw_go     = 1'b0;
		acc_go    = 1'b0;
		trig_go   = 1'b0;
		lvl2_try  = 1'b0;
		if (time_wr)
			reply_nxt = time_set ? bcgc_pkg::RP_TIME : bcgc_pkg::RP_ERROR;
		unique case (st_r)
		bcgc_pkg::ST_IDLE: if (cmd) begin
			reply_nxt = bcgc_pkg::RP_ERROR;
			unique case (op)
			bcgc_pkg::OP_TRIG: begin
				trig_go   = 1'b1;
				reply_nxt = bcgc_pkg::RP_TRIGGERED;
			end
			bcgc_pkg::OP_ACCESS: if (lvl_arg) begin
				acc_go    = granted;
				lvl2_try  = arg_a == 3'(`BCGC_LVL2);
				reply_nxt = granted ? bcgc_pkg::RP_GRANTED :
					bcgc_pkg::RP_DENIED;
			end
			bcgc_pkg::OP_CLOSE, bcgc_pkg::OP_OPEN: if (priv) begin
				st_nxt    = bcgc_pkg::ST_ASK1;
				reply_nxt = bcgc_pkg::RP_PROMPT1;
			end
			bcgc_pkg::OP_COPY:
				if (priv && grp_ok(arg_a) && grp_ok(arg_b)) begin
					st_nxt    = bcgc_pkg::ST_ASK2;
					reply_nxt = bcgc_pkg::RP_PROMPT2;
				end
			bcgc_pkg::OP_GSET: if (priv && grp_ok(arg_a)) begin
				st_nxt    = bcgc_pkg::ST_ASK2;
				reply_nxt = bcgc_pkg::RP_PROMPT2;
			end
			bcgc_pkg::OP_GQRY: reply_nxt = bcgc_pkg::RP_GROUP;
			bcgc_pkg::OP_PWSET:
				if (priv && lvl_arg && pw_valid(pw_stage_r)) begin
					pw_go     = 1'b1;
					reply_nxt = bcgc_pkg::RP_PW_SET;
				end
			bcgc_pkg::OP_PWLST: reply_nxt = bcgc_pkg::RP_PW_LIST;
			default: ;
			endcase
		end
		bcgc_pkg::ST_ASK1: if (cmd) begin
			if (op == bcgc_pkg::OP_YES) begin
				st_nxt    = bcgc_pkg::ST_ASK2;
				reply_nxt = bcgc_pkg::RP_PROMPT2;
			end else if (op == bcgc_pkg::OP_NO) begin
				st_nxt    = bcgc_pkg::ST_IDLE;
				reply_nxt = bcgc_pkg::RP_ABORTED;
			end else
				reply_nxt = bcgc_pkg::RP_ERROR;
		end
		bcgc_pkg::ST_ASK2: if (cmd) begin
			st_nxt    = bcgc_pkg::ST_IDLE;
			reply_nxt = bcgc_pkg::RP_ABORTED;
			if (op == bcgc_pkg::OP_YES) begin
				reply_nxt = brk_closed ? bcgc_pkg::RP_BRK_CLOSED :
					bcgc_pkg::RP_BRK_OPEN;
				unique case (pend_r)
				bcgc_pkg::OP_CLOSE:
					if (ctl_en_s && !brk_closed && !trip_r) begin
						close_go  = 1'b1;
						st_nxt    = bcgc_pkg::ST_CLOSING;
						reply_nxt = bcgc_pkg::RP_NONE;
					end
				bcgc_pkg::OP_OPEN: trip_go = ctl_en_s;
				bcgc_pkg::OP_COPY: begin
					copy_go   = 1'b1;
					reply_nxt = bcgc_pkg::RP_COPIED;
				end
				bcgc_pkg::OP_GSET: begin
					gvar_go   = 1'b1;
					reply_nxt = bcgc_pkg::RP_GROUP;
				end
				default: ;
				endcase
			end else if (op != bcgc_pkg::OP_NO) begin
				st_nxt    = bcgc_pkg::ST_ASK2;
				reply_nxt = bcgc_pkg::RP_ERROR;
			end
		end
		bcgc_pkg::ST_CLOSING: begin
			if (cmd)
				reply_nxt = bcgc_pkg::RP_ERROR;
			if (close_end) begin
				st_nxt    = bcgc_pkg::ST_IDLE;
				reply_nxt = brk_closed ? bcgc_pkg::RP_BRK_CLOSED :
					bcgc_pkg::RP_BRK_OPEN;
			end
		end
		default: st_nxt = bcgc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r    <= bcgc_pkg::ST_IDLE;
			reply_r <= bcgc_pkg::RP_NONE;
			pend_r  <= bcgc_pkg::OP_TRIG;
			a_r     <= `BCGC_GRP_MIN;
			b_r     <= `BCGC_GRP_MIN;
		end else begin
			st_r    <= st_nxt;
			reply_r <= reply_nxt;
			if (cmd && st_r == bcgc_pkg::ST_IDLE) begin
				pend_r <= op;
				a_r    <= arg_a;
				b_r    <= arg_b;
			end
		end
	end

	// ----------------------------------------------------------------
	// passwords and access level
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pw1_r <= 48'h0;
			pw2_r <= 48'h0;
			lvl_r <= 2'h0;
		end else begin
			if (pw_go && arg_a == 3'(`BCGC_LVL2))
				pw2_r <= pw_stage_r;
			else if (pw_go)
				pw1_r <= pw_stage_r;
			if (acc_go)
				lvl_r <= arg_a[1:0];
		end
	end

	// ----------------------------------------------------------------
	// breaker close and trip
	// ----------------------------------------------------------------
	logic [15:0] cft_ms_r;
	logic [15:0] minimum_trip_duration_ms_r;
	// ms ticks run free, so one extra ms guarantees the minimum
	wire         min_done = minimum_trip_duration_ms_r > minimum_trip_duration_r ||
		minimum_trip_duration_ms_r == 16'hFFFF;
	wire         trip_rel = trip_r && min_done &&
		(~|pickup_s || tgt_rst_s);
	assign cft_done  = cft_ms_r >= cft_r;
	assign close_end = close_r && (brk_closed || cft_done);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			close_r   <= 1'b0;
			trip_r    <= 1'b0;
			cft_ms_r  <= 16'h0;
			minimum_trip_duration_ms_r <= 16'h0;
		end else begin
			close_r  <= close_go || (close_r && !close_end);
			cft_ms_r <= close_go ? 16'h0 : ms_count(cft_ms_r, ms_tick);
			// a fresh open wins over a release in the same cycle
			trip_r   <= trip_go || (trip_r && !trip_rel);
			minimum_trip_duration_ms_r <= (trip_go && !trip_r) ? 16'h0 :
				ms_count(minimum_trip_duration_ms_r, ms_tick);
		end
	end

	// ----------------------------------------------------------------
	// setting groups, alarm and event pulses
	// ----------------------------------------------------------------
	logic        alarm_r;
	logic [9:0]  alarm_ms_r;
	logic        ev_cap_r;
	logic        ev_sum_r;
	logic        ev_clr_r;
	logic        copy_r;
	logic        demand_r;
	logic [2:0]  copy_src_r;
	logic [2:0]  copy_dst_r;
	wire         gsel_on = |(gsel_s & cfg_assign_r);
	wire  [2:0]  act_nxt = gsel_on ? act_r : gvar_r;
	wire         act_chg = act_nxt != act_r;
	// every alarm source shares one timer, so a new one restarts it
	wire         alarm_req = lvl2_try || pw_go || act_chg ||
		(copy_go && b_r == act_r);
	wire  [9:0]  alarm_nxt = alarm_req ? `BCGC_ALARM_MS :
		(ms_tick && alarm_ms_r != 10'h0) ? alarm_ms_r - 10'h1 :
		alarm_ms_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gvar_r     <= `BCGC_GRP_MIN;
			act_r      <= `BCGC_GRP_MIN;
			alarm_ms_r <= 10'h0;
			alarm_r    <= 1'b0;
			demand_r   <= 1'b0;
		end else begin
			if (gvar_go)
				gvar_r <= a_r;
			act_r      <= act_nxt;
			alarm_ms_r <= alarm_nxt;
			alarm_r    <= alarm_nxt != 10'h0;
			demand_r   <= act_chg && cfg_demand_reset_on_group_change_r;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ev_cap_r   <= 1'b0;
			ev_sum_r   <= 1'b0;
			ev_clr_r   <= 1'b0;
			copy_r     <= 1'b0;
			copy_src_r <= `BCGC_GRP_MIN;
			copy_dst_r <= `BCGC_GRP_MIN;
		end else begin
			ev_cap_r <= trig_go;
			ev_sum_r <= ev_cap_r;
			ev_clr_r <= copy_go;
			copy_r   <= copy_go;
			if (copy_go) begin
				copy_src_r <= a_r;
				copy_dst_r <= b_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;
	logic [31:0] rdata_r;

	always_comb begin
		rd_mux = 32'h0;
		unique case (addr)
		`BCGC_A_CMD:  rd_mux = {28'h0, reply_r};
		`BCGC_A_TIME: rd_mux = {11'h0, tim_r[16:12], 2'h0, tim_r[11:6],
			2'h0, tim_r[5:0]};
		`BCGC_A_CFG:  rd_mux = {18'h0, cfg_assign_r, 6'h0, cfg_demand_reset_on_group_change_r,
			cfg_inv_r};
		`BCGC_A_CFT:  rd_mux = {16'h0, cft_r};
		`BCGC_A_MINIMUM_TRIP_DURATION: rd_mux = {16'h0, minimum_trip_duration_r};
		`BCGC_A_GRP:  rd_mux = {25'h0, gvar_r, 1'b0, act_r};
		`BCGC_A_PW1LO: if (priv) rd_mux = pw1_r[31:0];
		`BCGC_A_PW1HI: if (priv) rd_mux = {16'h0, pw1_r[47:32]};
		`BCGC_A_PW2LO: if (priv) rd_mux = pw2_r[31:0];
		`BCGC_A_PW2HI: if (priv) rd_mux = {16'h0, pw2_r[47:32]};
		`BCGC_A_STAT: rd_mux = {20'h0, st_r, lvl_r, pw_byp_s, ctl_en_s,
			brk_closed, alarm_r, trip_r, close_r};
		default: ;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rdata_r <= 32'h0;
		else
			rdata_r <= rd_stb ? rd_mux : 32'h0;
	end

	assign rdata         = rdata_r;
	assign close_out     = close_r;
	assign trip_out      = trip_r;
	assign alarm_out     = alarm_r;
	assign event_capture = ev_cap_r;
	assign event_summary = ev_sum_r;
	assign event_clear   = ev_clr_r;
	assign copy_start    = copy_r;
	assign copy_src      = copy_src_r;
	assign copy_dst      = copy_dst_r;
	assign demand_reset  = demand_r;
	assign active_group  = act_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	close_lock_a: assert property ($rose(close_r) |->
		$past(ctl_en_s) && !$past(brk_closed) && !$past(trip_r))
		else $error("close energised against interlock");
	close_asks_a: assert property ($rose(close_r) |->
		$past(st_r) == bcgc_pkg::ST_ASK2)
		else $error("close without second confirmation");
	close_hold_a: assert property (close_r && !brk_closed &&
		!cft_done |=> close_r)
		else $error("close dropped early");
	open_jumper_a: assert property ($rose(trip_r) |->
		$past(ctl_en_s))
		else $error("trip without control jumper");
	trip_min_a: assert property (trip_r && !min_done |=>
		trip_r)
		else $error("trip shorter than minimum");
	trip_release_a: assert property ($fell(trip_r) |->
		$past(min_done) && ($past(pickup_s) == 8'h00 || $past(tgt_rst_s)))
		else $error("trip released while picked up");
	alarm_load_a: assert property (lvl2_try |=>
		alarm_r && alarm_ms_r == `BCGC_ALARM_MS)
		else $error("access attempt did not start alarm");
	group_hold_a: assert property (gsel_on |=>
		act_r == $past(act_r))
		else $error("active group moved under select input");
	group_alarm_a: assert property (act_r != $past(act_r) |->
		alarm_r && demand_r == $past(cfg_demand_reset_on_group_change_r))
		else $error("group change without alarm or demand reset");
	summary_seq_a: assert property (trig_go |=> ev_cap_r ##1
		ev_sum_r)
		else $error("event summary out of order");
endmodule : bcgc_top

// [hdl/bcgc_defines.svh]
`ifndef BCGC_DEFINES_SVH
`define BCGC_DEFINES_SVH
// clock and time base
`define BCGC_CLK_NS     5
`define BCGC_MS_NS      1000000
`define BCGC_MS_LAST    10'h3E7
`define BCGC_ALARM_MS   10'h3E8
// register word addresses
`define BCGC_A_CMD      4'h0
`define BCGC_A_TIME     4'h1
`define BCGC_A_CFG      4'h2
`define BCGC_A_CFT      4'h3
`define BCGC_A_MINIMUM_TRIP_DURATION     4'h4
`define BCGC_A_GRP      4'h5
`define BCGC_A_PWLO     4'h6
`define BCGC_A_PWHI     4'h7
`define BCGC_A_PW1LO    4'h8
`define BCGC_A_PW1HI    4'h9
`define BCGC_A_PW2LO    4'hA
`define BCGC_A_PW2HI    4'hB
`define BCGC_A_STAT     4'hC
// field positions
`define BCGC_F_OP       3:0
`define BCGC_F_A        6:4
`define BCGC_F_B        10:8
`define BCGC_F_SEP      31:24
`define BCGC_F_HMS      20:0
`define BCGC_F_INV      0
`define BCGC_F_DEMAND_RESET_ON_GROUP_CHANGE     1
`define BCGC_F_ASSIGN   13:8
`define BCGC_F_MS       15:0
`define BCGC_F_PWHI     15:0
// value limits and reset values
`define BCGC_HOUR_LAST  5'h17
`define BCGC_MIN_LAST   6'h3B
`define BCGC_CH_NONE    8'h00
`define BCGC_CH_MIN     8'h21
`define BCGC_CH_MAX     8'h7E
`define BCGC_CH_COLON   8'h3A
`define BCGC_CH_SEMI    8'h3B
`define BCGC_CH_SPACE   8'h20
`define BCGC_CH_COMMA   8'h2C
`define BCGC_CH_SLASH   8'h2F
`define BCGC_PW_CHARS   6
`define BCGC_GRP_MIN    3'h1
`define BCGC_GRP_MAX    3'h6
`define BCGC_LVL1       2'h1
`define BCGC_LVL2       2'h2
`define BCGC_CFT_RST    16'h0064
`define BCGC_MINIMUM_TRIP_DURATION_RST   16'h0064
`endif

// [hdl/bcgc_pkg.sv]
package bcgc_pkg;
	typedef enum logic [3:0] {
		ST_IDLE    = 4'h1,
		ST_ASK1    = 4'h2,
		ST_ASK2    = 4'h4,
		ST_CLOSING = 4'h8
	} bcgc_state_type;
	typedef enum logic [3:0] {
		OP_TRIG = 4'h1, OP_ACCESS = 4'h2, OP_CLOSE = 4'h3, OP_OPEN = 4'h4,
		OP_YES = 4'h5, OP_NO = 4'h6, OP_COPY = 4'h7, OP_GSET = 4'h8,
		OP_GQRY = 4'h9, OP_PWSET = 4'hA, OP_PWLST = 4'hB
	} bcgc_op_type;
	typedef enum logic [3:0] {
		RP_NONE = 4'h0, RP_TIME = 4'h1, RP_TRIGGERED = 4'h2,
		RP_PROMPT1 = 4'h3, RP_PROMPT2 = 4'h4, RP_BRK_CLOSED = 4'h5,
		RP_BRK_OPEN = 4'h6, RP_ABORTED = 4'h7, RP_COPIED = 4'h8,
		RP_GROUP = 4'h9, RP_PW_SET = 4'hA, RP_PW_LIST = 4'hB,
		RP_ERROR = 4'hC, RP_GRANTED = 4'hD, RP_DENIED = 4'hE
	} bcgc_reply_type;
endpackage : bcgc_pkg

// [sim/bcgc_breaker_model.sv]
`timescale 1ns/1ps
// breaker that follows its coils after a fixed mechanism delay
module bcgc_breaker_model #(
	parameter int DLY = 10
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic close_coil,
	input  wire logic trip_coil,
	output logic      aux_closed
);
	logic [7:0] cnt_r;
	logic       closed_r;
	wire        move = (close_coil != trip_coil) && (close_coil != closed_r);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r    <= 8'h00;
			closed_r <= 1'b0;
		end else if (move && cnt_r == 8'(DLY)) begin
			cnt_r    <= 8'h00;
			closed_r <= close_coil;
		end else begin
			cnt_r <= move ? cnt_r + 8'h01 : 8'h00;
		end
	end
	assign aux_closed = closed_r;
endmodule : bcgc_breaker_model

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
	logic        clk = 0, rstn = 0, wr_stb = 0, rd_stb = 0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic        control_enable_jumper = 1, password_bypass_jumper = 1;
	logic        breaker_aux_status_input, target_reset_button = 0;
	logic        irig_strobe = 0, close_out, trip_out, alarm_out;
	logic        event_capture, event_summary, event_clear;
	logic        copy_start, demand_reset;
	logic [5:0]  group_select_inputs = 6'h00;
	logic [7:0]  overcurrent_pickup_row = 8'h00;
	logic [16:0] irig_hms = 17'h0;
	logic [2:0]  copy_src, copy_dst, active_group;
	int          fail_count = 0, n_compared = 0, cyc = 0, n_dr = 0, n_ec = 0;
	logic [7:0]  sep [5] = '{8'h3A, 8'h3B, 8'h20, 8'h2C, 8'h2F};
	always #2.5 clk = ~clk;
	bcgc_top #(.MS_CYCLES(20)) dut (.clk, .rstn, .addr, .wdata, .wr_stb,
		.rd_stb, .rdata, .control_enable_jumper, .password_bypass_jumper,
		.breaker_aux_status_input, .group_select_inputs,
		.overcurrent_pickup_row, .target_reset_button, .irig_strobe,
		.irig_hms, .close_out, .trip_out, .alarm_out, .event_capture,
		.event_summary, .event_clear, .copy_start, .copy_src, .copy_dst,
		.demand_reset, .active_group);
	bcgc_breaker_model brk (.clk, .rstn, .close_coil(close_out),
		.trip_coil(trip_out), .aux_closed(breaker_aux_status_input));
	always @(posedge clk) begin
		cyc++;
		if (demand_reset === 1'b1) n_dr++;
		if (event_clear === 1'b1 && copy_start === 1'b1) n_ec++;
		if (cyc == 60000) begin
			fail_count++;
			stop_test;
		end
	end
	task stop_test;
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test
	task chk(input logic [31:0] s, e, input string nm);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task cmd(input logic [3:0] op, input logic [2:0] a, b);
		wr(4'h0, {21'h0, b, 1'b0, a, op});
	endtask : cmd
	task rep(input logic [3:0] e);
		rd(4'h0);
		chk(d[3:0], e, "reply");
	endtask : rep
	task yes2(input logic [3:0] op);
		cmd(op, 3'h0, 3'h0);
		cmd(bcgc_pkg::OP_YES, 3'h0, 3'h0);
		cmd(bcgc_pkg::OP_YES, 3'h0, 3'h0);
	endtask : yes2
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_trig_time;
		cmd(bcgc_pkg::OP_TRIG, 3'h0, 3'h0);
		chk(event_capture, 1'b1, "capture");
		#5 chk(event_summary, 1'b1, "summary");
		rep(bcgc_pkg::RP_TRIGGERED);
		for (int i = 0; i < 5; i++) begin
			wr(4'h1, {sep[i], 3'h0, 5'h17, 2'h0, 6'h1E, 2'h0, 6'(i)});
			rep(bcgc_pkg::RP_TIME);
			rd(4'h1);
			chk(d, {16'h0017, 2'h0, 6'h1E, 2'h0, 6'(i)}, "time");
		end
		wr(4'h1, {8'h2E, 24'h170000});
		rep(bcgc_pkg::RP_ERROR);
		@(posedge clk);
		irig_hms <= {5'h0C, 6'h22, 6'h11};
		irig_strobe <= 1'b1;
		repeat (4) @(posedge clk);
		irig_strobe <= 1'b0;
		rd(4'h1);
		chk(d, 32'h000C2211, "time code");
	endtask : t_trig_time
	task t_close;
		cmd(bcgc_pkg::OP_CLOSE, 3'h0, 3'h0);
		rep(bcgc_pkg::RP_PROMPT1);
		cmd(bcgc_pkg::OP_NO, 3'h0, 3'h0);
		rep(bcgc_pkg::RP_ABORTED);
		chk(close_out, 1'b0, "close aborted");
		yes2(bcgc_pkg::OP_CLOSE);
		#10 chk(close_out, 1'b1, "close on");
		repeat (30) @(posedge clk);
		#1 chk(close_out, 1'b0, "close off");
		rep(bcgc_pkg::RP_BRK_CLOSED);
		yes2(bcgc_pkg::OP_CLOSE);
		rep(bcgc_pkg::RP_BRK_CLOSED);
		chk(close_out, 1'b0, "close refused");
	endtask : t_close
	task t_open;
		@(posedge clk);
		overcurrent_pickup_row <= 8'h01;
		wr(4'h4, 32'h2);
		yes2(bcgc_pkg::OP_OPEN);
		repeat (60) @(posedge clk);
		#1 chk(trip_out, 1'b1, "trip held");
		@(posedge clk);
		overcurrent_pickup_row <= 8'h00;
		repeat (6) @(posedge clk);
		#1 chk(trip_out, 1'b0, "trip drop");
		yes2(bcgc_pkg::OP_OPEN);
		rep(bcgc_pkg::RP_BRK_OPEN);
		repeat (38) @(posedge clk);
		#1 chk(trip_out, 1'b1, "trip min");
		repeat (27) @(posedge clk);
		#1 chk(trip_out, 1'b0, "trip end");
		@(posedge clk);
		control_enable_jumper <= 1'b0;
		yes2(bcgc_pkg::OP_OPEN);
		#10 chk(trip_out, 1'b0, "no jumper");
		@(posedge clk);
		control_enable_jumper <= 1'b1;
	endtask : t_open
	task t_group;
		wr(4'h2, 32'h2);
		cmd(bcgc_pkg::OP_GSET, 3'h3, 3'h0);
		cmd(bcgc_pkg::OP_YES, 3'h0, 3'h0);
		repeat (3) @(posedge clk);
		#1 chk(active_group, 3'h3, "active");
		chk(alarm_out, 1'b1, "alarm");
		chk(n_dr, 1, "demand");
		@(posedge clk);
		group_select_inputs <= 6'h01;
		wr(4'h2, 32'h0102);
		cmd(bcgc_pkg::OP_GSET, 3'h5, 3'h0);
		cmd(bcgc_pkg::OP_YES, 3'h0, 3'h0);
		cmd(bcgc_pkg::OP_GQRY, 3'h0, 3'h0);
		rep(bcgc_pkg::RP_GROUP);
		rd(4'h5);
		chk(d, 32'h53, "frozen");
		@(posedge clk);
		group_select_inputs <= 6'h00;
		repeat (6) @(posedge clk);
		#1 chk(active_group, 3'h5, "released");
		chk(n_dr, 2, "demand 2");
		cmd(bcgc_pkg::OP_COPY, 3'h4, 3'h5);
		cmd(bcgc_pkg::OP_YES, 3'h0, 3'h0);
		rep(bcgc_pkg::RP_COPIED);
		chk({copy_src, copy_dst}, 6'h25, "copy");
		chk(n_ec, 1, "ev clear");
	endtask : t_group
	task t_pw;
		wr(4'h6, 32'h4B454942);
		wr(4'h7, 32'h0);
		cmd(bcgc_pkg::OP_PWSET, 3'h1, 3'h0);
		rep(bcgc_pkg::RP_PW_SET);
		rd(4'h8);
		chk(d, 32'h4B454942, "password");
		cmd(bcgc_pkg::OP_PWLST, 3'h0, 3'h0);
		rep(bcgc_pkg::RP_PW_LIST);
		wr(4'h6, 32'h2042);
		cmd(bcgc_pkg::OP_PWSET, 3'h1, 3'h0);
		rep(bcgc_pkg::RP_ERROR);
		cmd(bcgc_pkg::OP_ACCESS, 3'h2, 3'h0);
		rep(bcgc_pkg::RP_GRANTED);
		repeat (19960) @(posedge clk);
		#1 chk(alarm_out, 1'b1, "alarm on");
		repeat (60) @(posedge clk);
		#1 chk(alarm_out, 1'b0, "alarm off");
	endtask : t_pw
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t_trig_time;
		t_close;
		t_open;
		t_group;
		t_pw;
		stop_test;
	end
endmodule : tb
